// file: core/nbh_host.v
// nbh_host.v: host controller that drives a byte-wide nand port through its strobes
// assumes: one 25 MHz clock, pins sampled synchronously, external pull-up on ready_busy_n
`timescale 1ns/10ps
`include "nbh_defs.vh"
module nbh_host
#(
   parameter COL_W = `NBH_COL_W,
   parameter ROW_W = `NBH_ROW_W
)
(
   input  wire             core_clk,
   input  wire             sys_rst,
   // user request: kind 0 cmd, 1 addr, 2 write data, 3 read data, 4 wait ready
   input  wire             req_valid,
   output reg              req_ready,
   input  wire [2:0]       req_kind,
   input  wire [7:0]       req_byte,
   input  wire [2:0]       req_addr_cycles,
   input  wire [COL_W-1:0] req_col,
   input  wire [ROW_W-1:0] req_row,
   input  wire             req_protect_n,
   input  wire             req_standby,
   // read data out to user
   output reg              rd_valid,
   input  wire             rd_ready,
   output reg  [7:0]       rd_byte,
   // nand pins
   output reg              cle_q,
   output reg              ale_q,
   output reg              chip_sel_n_q,
   output reg              write_strobe_n_q,
   output reg              output_strobe_n_q,
   output reg              protect_n_q,
   output reg  [7:0]       shared_port_o,
   output reg              shared_port_oe,
   input  wire [7:0]       shared_port_i,
   input  wire             ready_busy_n
);
   // ****************************************
   // states and kinds
   // ****************************************
   localparam K_CMD = 3'd0, K_ADDR = 3'd1, K_WR = 3'd2, K_RD = 3'd3, K_WAIT = 3'd4;
   localparam S_IDLE = 3'd0, S_WLO = 3'd1, S_WHI = 3'd2, S_RLO = 3'd3, S_RHI = 3'd4, S_BUSY = 3'd5;
   localparam integer GUARD_I = `NBH_TWB_CYC + `NBH_TWHR_CYC;   // busy onset plus turnaround
   localparam [2:0]   GUARD_C = GUARD_I[2:0];                    // guard count at counter width
   reg [2:0]       state_q;            // strobe sequencer state
   reg [2:0]       kind_q;             // kind in progress
   reg [2:0]       acyc_q;             // address cycle count
   reg [2:0]       aidx_q;             // address cycle index
   reg [COL_W-1:0] col_q;              // column to send
   reg [ROW_W-1:0] row_q;              // row to send
   reg [2:0]       wait_q;             // guard delay counter
   // two-entry read buffer
   reg [7:0]       buf_q [0:1];        // storage words
   reg             wp_q;               // write pointer
   reg             rp_q;               // read pointer
   reg [1:0]       cnt_q;              // fill level
   wire            buf_full  = (cnt_q == 2'd2);
   wire            buf_push  = (state_q == S_RLO);
   wire            buf_pop   = rd_valid && rd_ready;
   // ****************************************
   // address byte select per cycle
   // ****************************************
   function [7:0] addr_byte;
      input [2:0]       idx;
      input [COL_W-1:0] col;
      input [ROW_W-1:0] row;
      begin
         case (idx)
            3'd0:    addr_byte = col[7:0];
            3'd1:    addr_byte = {4'h0, col[11:8]} & `NBH_COL_HI_MASK;
            3'd2:    addr_byte = row[7:0];
            3'd3:    addr_byte = row[15:8];
            3'd4:    addr_byte = {7'h00, row[16]} & `NBH_ROW_HI_MASK;
            default: addr_byte = 8'h00;
         endcase
      end
   endfunction
   // ****************************************
   // strobe sequencer
   // ****************************************
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q           <= S_IDLE;
         kind_q            <= 3'd0;
         acyc_q            <= 3'd0;
         aidx_q            <= 3'd0;
         col_q             <= {COL_W{1'b0}};
         row_q             <= {ROW_W{1'b0}};
         wait_q            <= 3'd0;
         req_ready         <= 1'b0;
         cle_q             <= 1'b0;
         ale_q             <= 1'b0;
         chip_sel_n_q      <= 1'b1;
         write_strobe_n_q  <= 1'b1;
         output_strobe_n_q <= 1'b1;
         protect_n_q       <= 1'b0;
         shared_port_o     <= 8'h00;
         shared_port_oe    <= 1'b0;
      end
      else
      begin
         protect_n_q <= req_protect_n;
         req_ready   <= 1'b0;
         case (state_q)
            // idle: strobes high, take next request
            S_IDLE:
            begin
               write_strobe_n_q  <= 1'b1;
               output_strobe_n_q <= 1'b1;
               shared_port_oe    <= 1'b0;
               cle_q             <= 1'b0;
               ale_q             <= 1'b0;
               // standby by raising chip select when idle
               chip_sel_n_q      <= req_standby && !req_valid;
               if (wait_q != 3'd0)
                  wait_q <= wait_q - 3'd1;
               else if (req_valid && !req_ready)
               begin
                  kind_q       <= req_kind;
                  chip_sel_n_q <= 1'b0;
                  case (req_kind)
                     K_CMD:
                     begin
                        if (!ready_busy_n && req_byte != `NBH_CMD_STATUS &&
                            req_byte != `NBH_CMD_MSTATUS && req_byte != `NBH_CMD_RESET)
                           state_q <= S_IDLE;
                        else
                        begin
                           cle_q            <= 1'b1;
                           shared_port_o    <= req_byte;
                           shared_port_oe   <= 1'b1;
                           write_strobe_n_q <= 1'b0;
                           state_q          <= S_WLO;
                        end
                     end
                     K_ADDR:
                     begin
                        ale_q            <= 1'b1;
                        col_q            <= req_col;
                        row_q            <= req_row;
                        acyc_q           <= req_addr_cycles;
                        aidx_q           <= 3'd0;
                        shared_port_o    <= addr_byte(3'd0, req_col, req_row);
                        shared_port_oe   <= 1'b1;
                        write_strobe_n_q <= 1'b0;
                        state_q          <= S_WLO;
                     end
                     K_WR:
                     begin
                        shared_port_o    <= req_byte;
                        shared_port_oe   <= 1'b1;
                        write_strobe_n_q <= 1'b0;
                        state_q          <= S_WLO;
                     end
                     K_RD:
                     begin
                        if (!buf_full && ready_busy_n)
                        begin
                           output_strobe_n_q <= 1'b0;
                           state_q           <= S_RLO;
                        end
                     end
                     default:
                        state_q <= S_BUSY;
                  endcase
               end
            end
            // write strobe low phase, rising edge next
            S_WLO:
            begin
               write_strobe_n_q <= 1'b1;
               state_q          <= S_WHI;
            end
            // write strobe high: hold, next address cycle or finish
            S_WHI:
            begin
               if (kind_q == K_ADDR && aidx_q + 3'd1 < acyc_q)
               begin
                  aidx_q           <= aidx_q + 3'd1;
                  shared_port_o    <= addr_byte(aidx_q + 3'd1, col_q, row_q);
                  write_strobe_n_q <= 1'b0;
                  state_q          <= S_WLO;
               end
               else
               begin
                  cle_q          <= 1'b0;
                  ale_q          <= 1'b0;
                  shared_port_oe <= 1'b0;
                  req_ready      <= 1'b1;
                  // busy may follow a confirm; allow busy to appear
                  wait_q         <= (kind_q == K_CMD) ? GUARD_C : 3'd0;
                  state_q        <= S_IDLE;
               end
            end
            // output strobe low: sample byte at end of the phase
            S_RLO:
            begin
               output_strobe_n_q <= 1'b1;
               state_q           <= S_RHI;
            end
            // output strobe high recovery
            S_RHI:
            begin
               req_ready <= 1'b1;
               state_q   <= S_IDLE;
            end
            S_BUSY:
            begin
               if (ready_busy_n)
               begin
                  req_ready <= 1'b1;
                  state_q   <= S_IDLE;
               end
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
   // ****************************************
   // two-entry read buffer
   // ****************************************
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'd0;
         rd_valid <= 1'b0;
         rd_byte  <= 8'h00;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end
      else
      begin
         // capture the byte presented by the strobe fall
         if (buf_push)
         begin
            buf_q[wp_q] <= shared_port_i;
            wp_q        <= ~wp_q;
         end
         if (buf_pop)
            rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
         // output register shows head entry
         if (buf_pop)
         begin
            rd_valid <= (cnt_q + {1'b0, buf_push}) > 2'd1;
            rd_byte  <= buf_push && cnt_q == 2'd1 ? shared_port_i : buf_q[~rp_q];
         end
         else if (!rd_valid && buf_push)
         begin
            rd_valid <= 1'b1;
            rd_byte  <= shared_port_i;
         end
      end
   end
endmodule

// file: include/nbh_defs.vh
// nbh_defs.vh: command codes, address layout and timing counts for the nand bus host
// assumes: included by core/nbh_host.v at 25 MHz core clock
`ifndef NBH_DEFS_VH
`define NBH_DEFS_VH
// ****************************************
// command codes
// ****************************************
`define NBH_CMD_READ1      8'h00
`define NBH_CMD_READ2      8'h30
`define NBH_CMD_COLCHG1    8'h05
`define NBH_CMD_COLCHG2    8'he0
`define NBH_CMD_SERIN      8'h80
`define NBH_CMD_PROG       8'h10
`define NBH_CMD_COLIN      8'h85
`define NBH_CMD_MPROG1     8'h11
`define NBH_CMD_MPROG2     8'h81
`define NBH_CMD_CBREAD     8'h35
`define NBH_CMD_ERASE1     8'h60
`define NBH_CMD_ERASE2     8'hd0
`define NBH_CMD_ID         8'h90
`define NBH_CMD_STATUS     8'h70
`define NBH_CMD_MSTATUS    8'h71
`define NBH_CMD_ECCSTAT    8'h7a
`define NBH_CMD_RESET      8'hff
// ****************************************
// address layout and geometry
// ****************************************
`define NBH_COL_W          12
`define NBH_ROW_W          17
`define NBH_PAGE_BYTES     2112
`define NBH_COL_HI_MASK    8'h0f
`define NBH_ROW_HI_MASK    8'h01
// ****************************************
// timing: busy onset and turnaround guard cycles (40 ns each)
// ****************************************
`define NBH_CLK_NS         40
`define NBH_TWHR_NS        60
`define NBH_TWHR_CYC       ((`NBH_TWHR_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`define NBH_TWB_NS         100
`define NBH_TWB_CYC        ((`NBH_TWB_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`endif

// file: sim/nbh_flash_model.sv
// nbh_flash_model.sv: behavioural device with one page buffer
// assumes: bench resolves the shared port and the pull-up
`timescale 1ns/10ps
module nbh_flash_model
#(
   parameter BUSY_NS = 4000
)
(
   input  wire       cle,
   input  wire       ale,
   input  wire       ce_n,
   input  wire       we_n,
   input  wire       re_n,
   input  wire       wp_n,
   input  wire [7:0] din,
   output reg  [7:0] dout,
   output wire       dout_oe,
   output reg        busy
);
   reg [7:0]  mem [0:2111];
   reg [7:0]  cmd_q = 8'h00;
   reg [2:0]  acnt_q = 3'h0;
   reg [11:0] col_q = 12'h000;
   reg [16:0] row_q = 17'h00000;
   reg        standby_q = 1'b1;
   integer    i;
   initial
   begin
      busy = 1'b0;
      dout = 8'h00;
      for (i = 0; i < 2112; i = i + 1) mem[i] = i[7:0];
   end
   always @(posedge ce_n) if (!busy) standby_q = 1'b1;
   always @(negedge ce_n) standby_q = 1'b0;
   always @(posedge we_n)
   if (!ce_n)
   begin
      // busy takes only 70, 71, ff
      if (cle && (!busy || din == 8'h70 || din == 8'h71 || din == 8'hff))
      begin
         cmd_q = din;
         acnt_q = 3'h0;
         // busy for read, or program and erase when unprotected
         if (din == 8'h30 || (wp_n && (din == 8'h10 || din == 8'hd0)))
         begin
            busy <= #50 1'b1;
            busy <= #(BUSY_NS) 1'b0;
         end
      end
      else if (ale && !busy)
      begin
         case (acnt_q)
            3'h0: col_q[7:0] = din;
            3'h1: col_q[11:8] = din[3:0];
            3'h2: row_q[7:0] = din;
            3'h3: row_q[15:8] = din;
            default: row_q[16] = din[0];
         endcase
         acnt_q = acnt_q + 3'h1;
      end
      else if (!cle && !ale && wp_n && !busy)
      begin
         mem[col_q] = din;
         col_q = col_q + 12'h001;
      end
   end
   // next byte and column step on each fall
   always @(negedge re_n)
   if (!ce_n && we_n)
   begin
      dout = mem[col_q];
      col_q = col_q + 12'h001;
   end
   // drive only while selected and strobe low
   assign dout_oe = !ce_n && we_n && !re_n;
endmodule

// file: sim/nbh_host_props.sv
// nbh_host_props.sv: pin and handshake checks for the nand bus host
// assumes: bound to nbh_host, one clock, sys_rst asynchronous active high
`timescale 1ns/10ps
module nbh_host_props (
   input wire       core_clk,
   input wire       sys_rst,
   input wire       req_ready,
   input wire       req_protect_n,
   input wire       rd_valid,
   input wire       rd_ready,
   input wire [7:0] rd_byte,
   input wire       cle_q,
   input wire       ale_q,
   input wire       write_strobe_n_q,
   input wire       output_strobe_n_q,
   input wire       protect_n_q,
   input wire [7:0] shared_port_o,
   input wire       shared_port_oe,
   input wire       ready_busy_n
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // command strobe low, then high with port held, then done
   sequence cmd_low; cle_q && !write_strobe_n_q; endsequence
   sequence cmd_done; cle_q && write_strobe_n_q && shared_port_oe ##1 !cle_q && req_ready; endsequence
   latch_excl_a: assert property (!(cle_q && ale_q))
      else $error("both latches high");
   wr_drive_a: assert property (!write_strobe_n_q |-> shared_port_oe && output_strobe_n_q)
      else $error("write strobe without drive");
   rd_float_a: assert property (!output_strobe_n_q |-> !shared_port_oe && write_strobe_n_q && !cle_q && !ale_q)
      else $error("port driven in read");
   cmd_walk_a: assert property (cmd_low |=> cmd_done)
      else $error("command cycle order");
   busy_filter_a: assert property (cle_q && $fell(write_strobe_n_q) && !$past(ready_busy_n)
      |-> shared_port_o inside {8'h70, 8'h71, 8'hff}) else $error("command sent while busy");
   protect_copy_a: assert property (!$past(sys_rst) |-> protect_n_q == $past(req_protect_n))
      else $error("protect not copied");
   rd_busy_a: assert property ($fell(output_strobe_n_q) |-> $past(ready_busy_n) ##1 output_strobe_n_q)
      else $error("read strobe while busy");
   rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_byte))
      else $error("read byte lost");
endmodule
bind nbh_host nbh_host_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .req_ready(req_ready),
   .req_protect_n(req_protect_n), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_byte(rd_byte),
   .cle_q(cle_q), .ale_q(ale_q), .write_strobe_n_q(write_strobe_n_q), .output_strobe_n_q(output_strobe_n_q),
   .protect_n_q(protect_n_q), .shared_port_o(shared_port_o), .shared_port_oe(shared_port_oe),
   .ready_busy_n(ready_busy_n));

// file: sim/tb_nbh_host.sv
// tb_nbh_host.sv: self-checking bench for the nand bus host
// assumes: device model and checker compiled first
`timescale 1ns/10ps
module tb_nbh_host;
   reg         core_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         req_valid = 1'b0;
   reg  [2:0]  req_kind = 3'h0;
   reg  [7:0]  req_byte = 8'h00;
   reg         req_protect_n = 1'b1;
   reg         rd_ready = 1'b0;
   reg         req_standby = 1'b0;
   reg         got = 1'b0;
   reg  [7:0]  last_q = 8'h00;
   wire        req_ready, rd_valid, cle_q, ale_q, cs_n, we_n, re_n, wp_n, oe, dev_oe, busy;
   wire [7:0]  rd_byte, port_o, dev_o;
   // released port shows the inverse of its last value
   wire [7:0]  port_bus = oe ? port_o : (dev_oe ? dev_o : ~last_q);
   integer     error_cnt = 0;
   integer     checked = 0;
   integer     cyc = 0;
   // ready line pulled up, device pulls it low
   nbh_host dut (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_kind(req_kind), .req_byte(req_byte), .req_addr_cycles(3'h5), .req_col(12'h83e),
      .req_row(17'h1a5c3), .req_protect_n(req_protect_n), .req_standby(req_standby), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_byte(rd_byte), .cle_q(cle_q), .ale_q(ale_q), .chip_sel_n_q(cs_n),
      .write_strobe_n_q(we_n), .output_strobe_n_q(re_n), .protect_n_q(wp_n), .shared_port_o(port_o),
      .shared_port_oe(oe), .shared_port_i(port_bus), .ready_busy_n(!busy));
   nbh_flash_model flash (.cle(cle_q), .ale(ale_q), .ce_n(cs_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
      .din(port_bus), .dout(dev_o), .dout_oe(dev_oe), .busy(busy));
   always #20 core_clk = ~core_clk;
   task chk(input [16:0] exp, input [16:0] seen, input [8*8-1:0] what);
   begin
      checked = checked + 1;
      if (exp !== seen)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   // one request held until answered or the limit runs out
   task req(input [2:0] k, input [7:0] b, input integer lim);
      integer n;
   begin
      req_kind = k;
      req_byte = b;
      req_valid = 1'b1;
      got = 1'b0;
      for (n = 0; n < lim && !got; n = n + 1)
      begin
         @(posedge core_clk);
         #1 got = req_ready;
      end
      req_valid = 1'b0;
      // one idle edge so the next request never rises in the same step
      @(posedge core_clk);
      #1;
   end
   endtask
   task pop(input [7:0] e);
   begin
      chk(17'h1, 17'(rd_valid), "rd_valid");
      chk(17'(e), 17'(rd_byte), "rd_byte");
      rd_ready = 1'b1;
      @(posedge core_clk);
      #1 rd_ready = 1'b0;
      @(posedge core_clk);
      #1;
   end
   endtask
   task t_program;
      integer i;
   begin
      req(3'h0, 8'h80, 20);
      req(3'h1, 8'h00, 60);
      chk(17'h0083e, 17'(flash.col_q), "col");
      chk(17'h1a5c3, flash.row_q, "row");
      req(3'h2, 8'ha5, 20);
      req(3'h2, 8'h3c, 20);
      chk(17'h000a5, 17'(flash.mem[2110]), "data");
      req(3'h0, 8'h10, 20);
      req(3'h0, 8'h90, 20);
      chk(17'h0, 17'(got), "refused");
      for (i = 0; i < 3; i = i + 1)
      begin
         req(3'h0, i == 0 ? 8'h70 : (i == 1 ? 8'h71 : 8'hff), 20);
         chk(17'h1, 17'(got), "busy_cmd");
      end
      req(3'h4, 8'h00, 300);
      chk(17'h1, 17'(got), "ready");
      $display("test program done");
   end
   endtask
   task t_read;
   begin
      req(3'h0, 8'h00, 20);
      req(3'h1, 8'h00, 60);
      req(3'h0, 8'h30, 20);
      req(3'h4, 8'h00, 300);
      req(3'h3, 8'h00, 20);
      req(3'h3, 8'h00, 20);
      req(3'h3, 8'h00, 20);
      chk(17'h0, 17'(got), "full");
      pop(8'ha5);
      pop(8'h3c);
      chk(17'h0, 17'(rd_valid), "drained");
      $display("test read done");
   end
   endtask
   task t_protect;
   begin
      req_protect_n = 1'b0;
      req(3'h0, 8'h80, 20);
      req(3'h1, 8'h00, 60);
      req(3'h2, 8'h77, 20);
      req(3'h0, 8'h10, 20);
      chk(17'h0, 17'(wp_n), "protect");
      chk(17'h000a5, 17'(flash.mem[2110]), "kept");
      // idle host with standby asked raises chip select
      req_standby = 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      #1 chk(17'h1, 17'(cs_n), "cs_n");
      chk(17'h1, 17'(flash.standby_q), "standby");
      req_standby = 1'b0;
      $display("test protect done");
   end
   endtask
   task end_of_test;
   begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   // last driven port value and the hang limit
   always @(posedge core_clk)
   begin
      if (oe || dev_oe) last_q <= port_bus;
      cyc = cyc + 1;
      if (cyc == 4000)
      begin
         error_cnt = error_cnt + 1;
         end_of_test;
      end
   end
   initial
   begin
      repeat (3) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      t_program;
      t_read;
      t_protect;
      end_of_test;
   end
endmodule
